/* common/tuner_pkg.sv */
// Constants shared by the tuner control register bank.
// Assumes a 250 MHz APB clock and 32-bit APB data.
package tuner_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam longint IRQ_PULSE_NS = 5_000_000;
  localparam int IRQ_PULSE_CYCLES = int'((IRQ_PULSE_NS * 1000) / CLK_PERIOD_PS);
  localparam int STEP_TIME_NS = 256;
  localparam int STEP_CYCLES = (STEP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 21;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_POWER = 8'h02;
  localparam logic [7:0] IDX_CHANNEL = 8'h03;
  localparam logic [7:0] IDX_CONFIG1 = 8'h04;
  localparam logic [7:0] IDX_CONFIG2 = 8'h05;
  localparam logic [7:0] IDX_STATUS = 8'h0A;
  localparam logic [7:0] IDX_READBACK = 8'h0B;

  // ==========================================================
  // Field positions
  localparam int POW_DOWN_BIT = 6;
  localparam int POW_UP_BIT = 0;
  localparam int POW_SCAN_BIT = 8;
  localparam int CH_TUNE_BIT = 15;
  localparam int CFG_DS_IRQ_BIT = 15;
  localparam int CFG_DONE_IRQ_BIT = 14;
  localparam int CFG_DS_EN_BIT = 12;
  localparam int CFG_EMPH_BIT = 11;
  localparam int CFG_AGC_OFF_BIT = 10;
  localparam int CFG_BLEND_LSB = 6;
  localparam int CFG_PIN_C_LSB = 4;
  localparam int CFG_PIN_B_LSB = 2;
  localparam int CFG_PIN_A_LSB = 0;
  localparam int CFG2_BAND_LSB = 6;
  localparam int CFG2_SPACE_LSB = 4;
  localparam int ST_DS_READY_BIT = 15;
  localparam int ST_DONE_BIT = 14;
  localparam int ST_FAIL_BIT = 13;
  localparam int ST_STEREO_BIT = 8;

  // ==========================================================
  // Reset values and encodings
  localparam logic [15:0] CHANNEL_RESET = 16'h0000;
  localparam logic [15:0] CONFIG1_RESET = 16'h0000;
  localparam logic [15:0] CONFIG2_RESET = 16'h0000;
  localparam logic [1:0] PIN_HIZ = 2'b00;
  localparam logic [1:0] PIN_SPECIAL = 2'b01;
  localparam logic [1:0] PIN_LOW = 2'b10;
  localparam logic [1:0] PIN_HIGH = 2'b11;
  localparam logic [18:0] BASE_WIDE_KHZ = 19'h1_55CC;
  localparam logic [18:0] BASE_LOW_KHZ = 19'h1_28E0;

  typedef enum logic [1:0] {st_idle, st_tune, st_scan} tune_state_t;

endpackage : tuner_pkg

/* rtl/tuner_channel_and_config_regs.sv */
// Tuner channel, power and configuration register bank with APB access.
// Assumes the analog front end supplies signal strength, channel-valid and
// data-group-ready levels asynchronously; all of them are synchronised here.
//
// Design decision made here: the APB register port.
module tuner_channel_and_config_regs #(
  parameter int PULSE_CYCLES = tuner_pkg::IRQ_PULSE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0] signal_strength,
  input wire logic channel_valid,
  input wire logic data_group_ready,
  output logic [18:0] tuned_freq_khz,
  output logic tuning_busy,
  output logic powerup_req,
  output logic powerdown_req,
  output logic radio_data_service_en,
  output logic emphasis_time_select,
  output logic gain_ctrl_off,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe,
  output logic pin_c_out,
  output logic pin_c_oe
);
  import tuner_pkg::*;

  // ==========================================================
  // Helper functions
  function automatic logic [9:0] band_top(input logic [1:0] band, input logic [1:0] space);
    logic [9:0] w;
    w = 10'd102;
    case (band)
      2'b01: w = 10'd160;
      2'b10: w = 10'd70;
      default: w = 10'd102;
    endcase
    case (space)
      2'b01: band_top = 10'(w << 1);
      2'b10: band_top = 10'(w << 2);
      default: band_top = w;
    endcase
  endfunction : band_top

  function automatic logic [1:0] pin_drive(input logic [1:0] mode, input logic special);
    // {oe, out}
    case (mode)
      PIN_SPECIAL: pin_drive = {1'b1, special};
      PIN_LOW: pin_drive = 2'b10;
      PIN_HIGH: pin_drive = 2'b11;
      default: pin_drive = 2'b00;
    endcase
  endfunction : pin_drive

  // ==========================================================
  // Input synchronisers
  logic [8:0] sync_a;
  logic [8:0] sync_b;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 9'h000;
      sync_b <= 9'h000;
    end else begin
      sync_a <= {data_group_ready, channel_valid, signal_strength};
      sync_b <= sync_a;
    end
  end

  logic [6:0] strength;
  logic valid_s;
  logic group_s;
  assign strength = sync_b[6:0];
  assign valid_s = sync_b[7];
  assign group_s = sync_b[8];

  // ==========================================================
  // Registers
  logic [9:0] channel_select;
  logic tune_req;
  logic [15:0] config1;
  logic [1:0] band_sel;
  logic [1:0] space_sel;
  logic scan_req;
  logic op_complete_flag;
  logic scan_fail_flag;
  logic data_group_ready_flag;
  logic two_channel_indicator;
  logic [9:0] current_channel_readback;
  tune_state_t state;
  logic [CNT_W-1:0] step_cnt;
  logic [CNT_W-1:0] pulse_cnt;

  logic [7:0] idx;
  logic addr_ok;
  logic wr_en;
  assign idx = paddr[9:2];
  assign addr_ok = (paddr[31:10] == 22'h00_0000) && (paddr[1:0] == 2'b00) &&
    (idx == IDX_POWER || idx == IDX_CHANNEL || idx == IDX_CONFIG1 ||
     idx == IDX_CONFIG2 || idx == IDX_STATUS || idx == IDX_READBACK);
  assign wr_en = psel && penable && pready && pwrite && addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerup_req <= 1'b0;
      powerdown_req <= 1'b0;
      scan_req <= 1'b0;
    end else if (wr_en && idx == IDX_POWER) begin
      powerup_req <= pwdata[POW_UP_BIT];
      powerdown_req <= pwdata[POW_DOWN_BIT];
      scan_req <= pwdata[POW_SCAN_BIT];
    end
  end

  // Reserved channel bits are dropped, not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_select <= CHANNEL_RESET[9:0];
      tune_req <= CHANNEL_RESET[CH_TUNE_BIT];
    end else if (wr_en && idx == IDX_CHANNEL) begin
      channel_select <= pwdata[9:0];
      tune_req <= pwdata[CH_TUNE_BIT];
    end
  end

  // Reserved bits 13, 9 and 8 are kept at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config1 <= CONFIG1_RESET;
    end else if (wr_en && idx == IDX_CONFIG1) begin
      config1 <= pwdata[15:0] & 16'hDCFF;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      band_sel <= CONFIG2_RESET[CFG2_BAND_LSB +: 2];
      space_sel <= CONFIG2_RESET[CFG2_SPACE_LSB +: 2];
    end else if (wr_en && idx == IDX_CONFIG2) begin
      band_sel <= pwdata[CFG2_BAND_LSB +: 2];
      space_sel <= pwdata[CFG2_SPACE_LSB +: 2];
    end
  end

  assign radio_data_service_en = config1[CFG_DS_EN_BIT];
  assign emphasis_time_select = config1[CFG_EMPH_BIT];
  assign gain_ctrl_off = config1[CFG_AGC_OFF_BIT];

  // ==========================================================
  // Tune and scan sequencer
  logic at_top;
  assign at_top = (current_channel_readback >= band_top(band_sel, space_sel));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      step_cnt <= '0;
      current_channel_readback <= 10'h000;
      op_complete_flag <= 1'b0;
      scan_fail_flag <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          // Set wins: clear only happens while idle with both requests low
          if (!tune_req && !scan_req) begin
            op_complete_flag <= 1'b0;
            scan_fail_flag <= 1'b0;
          end else if (!op_complete_flag) begin
            step_cnt <= CNT_W'(STEP_CYCLES);
            if (tune_req) begin
              state <= st_tune;
            end else begin
              state <= st_scan;
            end
          end
        end
        st_tune: begin
          if (step_cnt > CNT_W'(1)) begin
            step_cnt <= step_cnt - CNT_W'(1);
          end else begin
            current_channel_readback <= channel_select;
            op_complete_flag <= 1'b1;
            state <= st_idle;
          end
        end
        default: begin
          // Scan walks upward; the written channel is left untouched
          if (!scan_req) begin
            state <= st_idle;
          end else if (step_cnt > CNT_W'(1)) begin
            step_cnt <= step_cnt - CNT_W'(1);
          end else if (valid_s) begin
            op_complete_flag <= 1'b1;
            state <= st_idle;
          end else if (at_top) begin
            op_complete_flag <= 1'b1;
            scan_fail_flag <= 1'b1;
            state <= st_idle;
          end else begin
            current_channel_readback <= current_channel_readback + 10'h001;
            step_cnt <= CNT_W'(STEP_CYCLES);
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tuning_busy <= 1'b0;
    end else begin
      tuning_busy <= (state != st_idle);
    end
  end

  // ==========================================================
  // Frequency of the tuned channel
  logic [8:0] space_khz;
  logic [18:0] base_khz;
  always_comb begin
    case (space_sel)
      2'b01: space_khz = 9'd100;
      2'b10: space_khz = 9'd50;
      default: space_khz = 9'd200;
    endcase
    if (band_sel == 2'b00) begin
      base_khz = BASE_WIDE_KHZ;
    end else begin
      base_khz = BASE_LOW_KHZ;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tuned_freq_khz <= 19'h0_0000;
    end else begin
      tuned_freq_khz <= 19'(space_khz * current_channel_readback) + base_khz;
    end
  end

  // ==========================================================
  // Stereo indicator and data-group flag
  logic [6:0] blend_low;
  always_comb begin
    case (config1[CFG_BLEND_LSB +: 2])
      2'b01: blend_low = 7'd37;
      2'b10: blend_low = 7'd19;
      2'b11: blend_low = 7'd25;
      default: blend_low = 7'd31;
    endcase
  end

  logic done_prev;
  logic group_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      two_channel_indicator <= 1'b0;
      data_group_ready_flag <= 1'b0;
      done_prev <= 1'b0;
      group_prev <= 1'b0;
    end else begin
      two_channel_indicator <= (strength > blend_low);
      data_group_ready_flag <= group_s && radio_data_service_en;
      done_prev <= op_complete_flag;
      group_prev <= data_group_ready_flag;
    end
  end

  // ==========================================================
  // Interrupt pulse on pin two
  logic irq_event;
  assign irq_event = (config1[CFG_PIN_B_LSB +: 2] == PIN_SPECIAL) &&
    ((config1[CFG_DS_IRQ_BIT] && data_group_ready_flag && !group_prev) ||
     (config1[CFG_DONE_IRQ_BIT] && op_complete_flag && !done_prev));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt <= '0;
    end else if (irq_event) begin
      pulse_cnt <= CNT_W'(PULSE_CYCLES);
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - CNT_W'(1);
    end
  end

  // ==========================================================
  // Pin drivers
  logic [1:0] drv_a;
  logic [1:0] drv_b;
  logic [1:0] drv_c;
  assign drv_a = pin_drive(config1[CFG_PIN_A_LSB +: 2], 1'b0);
  assign drv_b = pin_drive(config1[CFG_PIN_B_LSB +: 2], !(irq_event || pulse_cnt > CNT_W'(1)));
  assign drv_c = pin_drive(config1[CFG_PIN_C_LSB +: 2], two_channel_indicator);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pin_a_oe, pin_a_out} <= 2'b00;
      {pin_b_oe, pin_b_out} <= 2'b00;
      {pin_c_oe, pin_c_out} <= 2'b00;
    end else begin
      // Reserved mode on pin one is left undriven
      {pin_a_oe, pin_a_out} <= (config1[CFG_PIN_A_LSB +: 2] == PIN_SPECIAL) ? 2'b00 : drv_a[1:0];
      {pin_b_oe, pin_b_out} <= drv_b[1:0];
      {pin_c_oe, pin_c_out} <= drv_c[1:0];
    end
  end

  // ==========================================================
  // APB answer: zero wait states, data latched in setup
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (idx == IDX_POWER) begin
      rd_word[POW_UP_BIT] = powerup_req;
      rd_word[POW_DOWN_BIT] = powerdown_req;
      rd_word[POW_SCAN_BIT] = scan_req;
    end else if (idx == IDX_CHANNEL) begin
      rd_word[CH_TUNE_BIT] = tune_req;
      rd_word[9:0] = channel_select;
    end else if (idx == IDX_CONFIG1) begin
      rd_word[15:0] = config1;
    end else if (idx == IDX_CONFIG2) begin
      rd_word[CFG2_BAND_LSB +: 2] = band_sel;
      rd_word[CFG2_SPACE_LSB +: 2] = space_sel;
    end else if (idx == IDX_STATUS) begin
      rd_word[ST_DS_READY_BIT] = data_group_ready_flag;
      rd_word[ST_DONE_BIT] = op_complete_flag;
      rd_word[ST_FAIL_BIT] = scan_fail_flag;
      rd_word[ST_STEREO_BIT] = two_channel_indicator;
    end else if (idx == IDX_READBACK) begin
      rd_word[9:0] = current_channel_readback;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite && addr_ok) begin
        prdata <= rd_word;
      end else if (psel && !penable) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule : tuner_channel_and_config_regs

/* tb/tuner_regs_checker.sv */
// Port-level checker for the tuner register bank.
// Assumes one pclk domain with presetn as its only reset.
module tuner_regs_checker #(
  parameter int PULSE_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tuning_busy,
  input wire logic powerup_req,
  input wire logic powerdown_req,
  input wire logic radio_data_service_en,
  input wire logic emphasis_time_select,
  input wire logic gain_ctrl_off,
  input wire logic pin_b_out,
  input wire logic pin_b_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_acc;
  logic [7:0] wr_age;
  logic [31:0] low_cnt;
  assign wr_acc = psel && penable && pwrite && pready;
  // ==========================================================
  // Helper counters
  // Age saturates so a long idle never wraps into a false recent write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_age <= 8'hFF;
    end else if (wr_acc) begin
      wr_age <= 8'h00;
    end else if (wr_age != 8'hFF) begin
      wr_age <= wr_age + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 32'h0000_0000;
    end else begin
      low_cnt <= (pin_b_oe && !pin_b_out) ? low_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  // ==========================================================
  // Assertions
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("pready held too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_READ_UPPER: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000) else $error("upper bits set");
  AST_POWER_RESET: assert property ($rose(presetn) |-> !powerup_req && !powerdown_req)
    else $error("power bits not clear after reset");
  AST_CFG_HOLD: assert property ($changed({radio_data_service_en, emphasis_time_select,
    gain_ctrl_off, powerup_req, powerdown_req}) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("control bit moved without a write");
  AST_TUNE_CAUSE: assert property ($rose(tuning_busy) |-> wr_age <= 8'h04)
    else $error("busy rose without a request");
  AST_PULSE_LEN: assert property ($rose(pin_b_out) && pin_b_oe && $past(pin_b_oe) && wr_age > 8'h03
    |-> low_cnt >= PULSE_CYCLES)
    else $error("interrupt pulse too short");
  AST_BUSY_HOLD: assert property ($rose(tuning_busy) |-> tuning_busy [*8])
    else $error("operation ended too early");
  cover property ($rose(tuning_busy));
  cover property ($fell(pin_b_out) && pin_b_oe);
  cover property (pslverr);
endmodule : tuner_regs_checker

bind tuner_channel_and_config_regs tuner_regs_checker #(.PULSE_CYCLES(PULSE_CYCLES)) i_tuner_regs_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .tuning_busy, .powerup_req,
  .powerdown_req, .radio_data_service_en, .emphasis_time_select, .gain_ctrl_off, .pin_b_out, .pin_b_oe
);

/* tb/tuner_front_end_model.sv */
// Behavioural model of the analog front end beside the register bank.
// Assumes the bench sets wanted levels; they appear LAG cycles later.
module tuner_front_end_model #(
  parameter int LAG = 2
) (
  input wire logic pclk,
  input wire logic [6:0] want_strength,
  input wire logic want_valid,
  input wire logic want_group,
  output logic [6:0] signal_strength,
  output logic channel_valid,
  output logic data_group_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] stage [LAG];
  // ==========================================================
  // Slow settling, so the bank cannot rely on same-cycle levels
  always_ff @(posedge pclk) begin
    stage[0] <= {want_strength, want_valid, want_group};
    for (int i = 1; i < LAG; i++) begin
      stage[i] <= stage[i - 1];
    end
  end
  assign {signal_strength, channel_valid, data_group_ready} = stage[LAG - 1];
endmodule : tuner_front_end_model

/* tb/tuner_channel_and_config_regs_test.sv */
// Self-checking bench for the tuner register bank over APB.
// Assumes the front-end model feeds the analog-side inputs.
module tuner_channel_and_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tuner_pkg::*;
  localparam int PULSE = 20;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [6:0] want_strength, signal_strength;
  logic want_valid, want_group, channel_valid, data_group_ready;
  logic [18:0] tuned_freq_khz;
  logic tuning_busy, powerup_req, powerdown_req, radio_data_service_en, emphasis_time_select, gain_ctrl_off;
  logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, pin_c_out, pin_c_oe;
  int fail_count = 0;
  int comparisons = 0;
  tuner_channel_and_config_regs #(.PULSE_CYCLES(PULSE)) i_tuner_channel_and_config_regs (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .signal_strength, .channel_valid, .data_group_ready, .tuned_freq_khz, .tuning_busy, .powerup_req,
    .powerdown_req, .radio_data_service_en, .emphasis_time_select, .gain_ctrl_off,
    .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe, .pin_c_out, .pin_c_oe
  );
  tuner_front_end_model #(.LAG(2)) i_tuner_front_end_model (
    .pclk, .want_strength, .want_valid, .want_group, .signal_strength, .channel_valid, .data_group_ready
  );
  // ==========================================================
  // Common tasks
  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic timeout();
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run();
  endtask : timeout
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h00_0000, idx} << 2;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) timeout();
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Extra edge lets registered outputs settle before anyone looks
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
    @(posedge pclk);
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0000_0000, r, e);
    chk(r & mask, exp);
  endtask : rd_chk
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (tuning_busy !== lvl) begin
      @(posedge pclk);
      n++;
      if (n > lim) timeout();
    end
  endtask : wait_busy
  task automatic pulse_chk(input int lim);
    int n;
    n = 0;
    while (pin_b_out !== 1'b0) begin
      @(posedge pclk);
      n++;
      if (n > lim) timeout();
    end
    n = 0;
    while (pin_b_out === 1'b0 && n <= PULSE + 4) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n), 32'(PULSE));
  endtask : pulse_chk
  // ==========================================================
  // Scenarios
  task automatic reset_values();
    chk({powerup_req, powerdown_req, radio_data_service_en, emphasis_time_select, gain_ctrl_off}, 0);
    chk({pin_a_oe, pin_b_oe, pin_c_oe}, 32'h0000_0000);
    rd_chk(IDX_POWER, 32'h0000_0041, 32'h0000_0000);
    rd_chk(IDX_CHANNEL, ALL, 32'h0000_0000);
    rd_chk(IDX_CONFIG1, ALL, 32'h0000_0000);
    rd_chk(IDX_CONFIG2, 32'h0000_00F0, 32'h0000_0000);
  endtask : reset_values
  task automatic config_fields();
    wr(IDX_CONFIG1, 32'h0000_DCFF);
    rd_chk(IDX_CONFIG1, ALL, 32'h0000_DCFF);
    chk({radio_data_service_en, emphasis_time_select, gain_ctrl_off}, 32'h0000_0007);
    wr(IDX_POWER, 32'h0000_0041);
    chk({powerup_req, powerdown_req}, 32'h0000_0003);
    wr(IDX_POWER, 32'h0000_0000);
    wr(IDX_CONFIG1, 32'h0000_0000);
    chk({radio_data_service_en, emphasis_time_select, gain_ctrl_off}, 32'h0000_0000);
  endtask : config_fields
  task automatic pin_modes();
    logic [1:0] m;
    logic [5:0] exp;
    want_strength <= 7'h28;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      exp = {m[1], m == 2'b11, m != 2'b00, m[0], m != 2'b00, m[0]};
      wr(IDX_CONFIG1, 32'(m) * 32'h0000_0015);
      chk({pin_a_oe, pin_a_oe & pin_a_out, pin_b_oe, pin_b_oe & pin_b_out, pin_c_oe, pin_c_oe & pin_c_out}, exp);
    end
  endtask : pin_modes
  task automatic blend_levels();
    logic [6:0] lows [4];
    lows = '{7'h1F, 7'h25, 7'h13, 7'h19};
    for (int b = 0; b < 4; b++) begin
      wr(IDX_CONFIG1, (32'(b) << 6) | 32'h0000_0010);
      for (int s = 0; s < 2; s++) begin
        want_strength <= lows[b] + 7'(s);
        repeat (8) @(posedge pclk);
        chk(pin_c_out, 32'(s));
      end
    end
  endtask : blend_levels
  task automatic tune_steps();
    logic [31:0] cfg [3];
    logic [18:0] sp [3];
    logic [9:0] ch [3];
    logic [18:0] f;
    cfg = '{32'h0000_0000, 32'h0000_0050, 32'h0000_00A0};
    sp = '{19'h0_00C8, 19'h0_0064, 19'h0_0032};
    ch = '{10'h00A, 10'h005, 10'h003};
    wr(IDX_CONFIG1, 32'h0000_4004);
    for (int i = 0; i < 3; i++) begin
      f = (i == 0 ? BASE_WIDE_KHZ : BASE_LOW_KHZ) + sp[i] * 19'(ch[i]);
      wr(IDX_CONFIG2, cfg[i]);
      wr(IDX_CHANNEL, 32'h0000_8000 | 32'(ch[i]));
      wait_busy(1'b1, 10);
      pulse_chk(300);
      wait_busy(1'b0, 300);
      rd_chk(IDX_STATUS, 32'h0000_4000, 32'h0000_4000);
      rd_chk(IDX_READBACK, 32'h0000_03FF, 32'(ch[i]));
      chk(tuned_freq_khz, f);
      wr(IDX_CHANNEL, 32'h0000_8000 | 32'(ch[i] ^ 10'h001));
      repeat (100) @(posedge pclk);
      chk(tuning_busy, 32'h0000_0000);
      wr(IDX_CHANNEL, 32'(ch[i]));
      rd_chk(IDX_STATUS, 32'h0000_4000, 32'h0000_0000);
    end
  endtask : tune_steps
  task automatic scan_to_edge();
    wr(IDX_CONFIG2, 32'h0000_0080);
    wr(IDX_POWER, 32'h0000_0100);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 6000);
    rd_chk(IDX_STATUS, 32'h0000_6000, 32'h0000_6000);
    rd_chk(IDX_READBACK, 32'h0000_03FF, 32'h0000_0046);
    rd_chk(IDX_CHANNEL, ALL, 32'h0000_0003);
    wr(IDX_POWER, 32'h0000_0000);
    rd_chk(IDX_STATUS, 32'h0000_6000, 32'h0000_0000);
    // Valid channel stops the scan after its first step time, without the fail flag
    want_valid <= 1'b1;
    wr(IDX_POWER, 32'h0000_0100);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 200);
    rd_chk(IDX_STATUS, 32'h0000_6000, 32'h0000_4000);
    rd_chk(IDX_READBACK, 32'h0000_03FF, 32'h0000_0046);
    wr(IDX_POWER, 32'h0000_0000);
    want_valid <= 1'b0;
  endtask : scan_to_edge
  task automatic group_pulse();
    // Let the completion pulse of the last scan run out first
    repeat (PULSE + 2) @(posedge pclk);
    wr(IDX_CONFIG1, 32'h0000_9004);
    want_group <= 1'b1;
    pulse_chk(50);
    rd_chk(IDX_STATUS, 32'h0000_8000, 32'h0000_8000);
    want_group <= 1'b0;
  endtask : group_pulse
  task automatic unmapped_access();
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'hFF, 32'h0000_0000, r, e);
    chk(e, 32'h0000_0001);
    chk(r, 32'h0000_0000);
  endtask : unmapped_access
  // ==========================================================
  // Clock and main sequence
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    want_strength = 7'h00;
    want_valid = 1'b0;
    want_group = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_values();
    config_fields();
    pin_modes();
    blend_levels();
    tune_steps();
    scan_to_edge();
    group_pulse();
    unmapped_access();
    complete_run();
  end
endmodule : tuner_channel_and_config_regs_test
